// ---- bench/irq_peer_model.sv ----
// ************************************************************
// interrupting peripheral: request level and acknowledge answer
// ************************************************************
module irq_peer_model (
	// clock and reset
	input  wire logic       clk_in,
	input  wire logic       rst_in,
	// bench controls
	input  wire logic [2:0] level_in,
	input  wire logic [1:0] mode_in,
	input  wire logic [7:0] vec_in,
	input  wire logic       slow_in,
	// acknowledge cycle
	input  wire logic       iack_req_in,
	output      logic [2:0] lines_out,
	output      logic       done_out,
	output      logic       berr_out,
	output      logic       autovec_out,
	output      logic [7:0] vector_out
);
	timeunit 1ns;
	timeprecision 1ps;
	logic [2:0] wait_cnt;
	logic [7:0] churn;
	// the bench holds a level until its acknowledge has ended
	assign lines_out = level_in;
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			wait_cnt <= 3'h0;
			churn <= 8'ha5;
			done_out <= 1'h0;
			berr_out <= 1'h0;
			autovec_out <= 1'h0;
			vector_out <= 8'h00;
		end else begin
			churn <= ~churn;
			done_out <= 1'h0;
			// qualifiers carry noise outside the answer, so stale values never pass
			berr_out <= churn[0];
			autovec_out <= churn[1];
			vector_out <= churn;
			if (iack_req_in && !done_out) begin
				if (wait_cnt == (slow_in ? 3'h5 : 3'h0)) begin
					wait_cnt <= 3'h0;
					done_out <= 1'h1;
					berr_out <= (mode_in == 2'h2);
					autovec_out <= (mode_in == 2'h1);
					// mode 3 stands for a vector register never set since reset
					vector_out <= (mode_in == 2'h3) ? 8'h0f : vec_in;
				end else begin
					wait_cnt <= wait_cnt + 3'h1;
				end
			end
		end
	end
endmodule // irq_peer_model

// ---- bench/tb_cpu_exception_sequencer.sv ----
`include "exc_seq_params.svh"
`define CHK(nm, e, g) begin tests_run++; if ((g) !== (e)) begin miscompares++; \
	$display("unexpected %s: expected %h, seen %h", nm, e, g); end end

module tb_cpu_exception_sequencer;
	import exc_seq_pkg::*;
	timeunit 1ns;
	timeprecision 1ps;
	// ************************************************************
	// signals
	// ************************************************************
	logic clk_in = 1'h0, rst_in = 1'h0, boundary_in = 1'h1, breakpoint_in = 1'h0;
	logic [7:0] s_axi_awaddr_in = 8'h00, s_axi_araddr_in = 8'h00, forced_vec_in = 8'h20;
	logic [31:0] s_axi_wdata_in = 32'h0;
	logic [3:0] s_axi_wstrb_in = 4'hf, ret_format_in = 4'h0;
	logic s_axi_awvalid_in = 1'h0, s_axi_wvalid_in = 1'h0, s_axi_bready_in = 1'h0;
	logic s_axi_arvalid_in = 1'h0, s_axi_rready_in = 1'h0, instr_start_in = 1'h0;
	logic instr_done_in = 1'h0, flow_change_in = 1'h0, not_executed_in = 1'h0;
	logic halt_op_in = 1'h0, forced_exc_in = 1'h0, ret_req_in = 1'h0;
	logic ret_access_err_in = 1'h0, ret_exc_fault_in = 1'h0;
	logic rewrite_ok_in = 1'h0, rewrite_err_in = 1'h0;
	logic [15:0] ret_psw_in = 16'h2500, ret_word14_in = 16'h0;
	logic s_axi_awready_out, s_axi_wready_out, s_axi_bvalid_out, s_axi_arready_out;
	logic s_axi_rvalid_out, iack_req_out, rewrite_req_out, ret_done_out, exc_take_out;
	logic bkpt_ack_out, stop_inhibit_out, halted_out;
	logic [1:0] s_axi_bresp_out, s_axi_rresp_out;
	logic [31:0] s_axi_rdata_out;
	logic [2:0] iack_level_out, interrupt_request_lines_in;
	logic [3:0] iack_space_out;
	logic [4:0] sp_increment_out;
	logic [7:0] exc_vector_out, iack_vector_in;
	frame_t exc_frame_out;
	logic [15:0] exc_psw_out, processor_status_word_out;
	logic iack_done_in, iack_berr_in, iack_autovec_in;
	logic [2:0] pl = 3'h0;
	logic [1:0] pm = 2'h0;
	logic ps = 1'h0, ack_prev = 1'h0, rw_fail = 1'h0;
	logic [7:0] ack_info = 8'h00;
	logic [31:0] d;
	logic [15:0] evq[$];
	int stop_cnt = 0, miscompares = 0, tests_run = 0;

	cpu_exception_sequencer cpu_exception_sequencer_i (.clk_in, .rst_in, .s_axi_awaddr_in,
		.s_axi_awvalid_in, .s_axi_awready_out, .s_axi_wdata_in, .s_axi_wstrb_in,
		.s_axi_wvalid_in, .s_axi_wready_out, .s_axi_bresp_out, .s_axi_bvalid_out,
		.s_axi_bready_in, .s_axi_araddr_in, .s_axi_arvalid_in, .s_axi_arready_out,
		.s_axi_rdata_out, .s_axi_rresp_out, .s_axi_rvalid_out, .s_axi_rready_in,
		.instr_start_in, .instr_done_in, .flow_change_in, .not_executed_in, .halt_op_in,
		.forced_exc_in, .forced_vec_in, .boundary_in, .breakpoint_in,
		.interrupt_request_lines_in, .iack_done_in, .iack_berr_in, .iack_autovec_in,
		.iack_vector_in, .iack_req_out, .iack_level_out, .iack_space_out, .ret_req_in,
		.ret_format_in, .ret_psw_in, .ret_word14_in, .ret_access_err_in, .ret_exc_fault_in,
		.rewrite_ok_in, .rewrite_err_in, .rewrite_req_out, .ret_done_out, .sp_increment_out,
		.exc_take_out, .exc_vector_out, .exc_frame_out, .exc_psw_out, .bkpt_ack_out,
		.stop_inhibit_out, .halted_out, .processor_status_word_out);

	irq_peer_model irq_peer_model_i (.clk_in, .rst_in, .level_in(pl), .mode_in(pm),
		.vec_in(8'h40), .slow_in(ps), .iack_req_in(iack_req_out),
		.lines_out(interrupt_request_lines_in), .done_out(iack_done_in),
		.berr_out(iack_berr_in), .autovec_out(iack_autovec_in), .vector_out(iack_vector_in));

	always #12.5 clk_in = ~clk_in;

	// event log keeps the order in which the sequencer acted
	always @(posedge clk_in) begin
		if (exc_take_out) evq.push_back({6'h10, exc_frame_out, exc_vector_out});
		if (bkpt_ack_out) evq.push_back(16'h8000);
		if (ret_done_out) evq.push_back({11'h100, sp_increment_out});
		if (stop_inhibit_out) stop_cnt++;
		if (bkpt_ack_out) breakpoint_in <= 1'h0;
		rewrite_ok_in <= rewrite_req_out && !rewrite_ok_in && !rewrite_err_in && !rw_fail;
		rewrite_err_in <= rewrite_req_out && !rewrite_ok_in && !rewrite_err_in && rw_fail;
		if (iack_req_out && !ack_prev) ack_info <= {iack_space_out, 1'h0, iack_level_out};
		ack_prev <= iack_req_out;
	end

	// ************************************************************
	// tasks
	// ************************************************************
	function automatic logic [15:0] tk(input logic [7:0] v, input frame_t f);
		return {6'h10, f, v};
	endfunction

	task automatic test_done();
		$display("comparisons %0d, mismatches %0d", tests_run, miscompares);
		if (miscompares == 0 && tests_run > 0) $display("[ PASS ]");
		else $display("[ FAIL ]");
		$finish;
	endtask

	task automatic axi_wr(input logic [7:0] a, input logic [31:0] v, input logic [1:0] er);
		@(posedge clk_in);
		s_axi_awaddr_in <= a;
		s_axi_wdata_in <= v;
		s_axi_awvalid_in <= 1'h1;
		s_axi_wvalid_in <= 1'h1;
		s_axi_bready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			if (s_axi_awvalid_in && s_axi_awready_out) s_axi_awvalid_in <= 1'h0;
			if (s_axi_wvalid_in && s_axi_wready_out) s_axi_wvalid_in <= 1'h0;
		end while (!s_axi_bvalid_out);
		s_axi_bready_in <= 1'h0;
		`CHK("bresp", er, s_axi_bresp_out)
	endtask

	task automatic axi_rd(input logic [7:0] a, output logic [31:0] v, input logic [1:0] er);
		@(posedge clk_in);
		s_axi_araddr_in <= a;
		s_axi_arvalid_in <= 1'h1;
		s_axi_rready_in <= 1'h1;
		do begin
			@(posedge clk_in);
			if (s_axi_arvalid_in && s_axi_arready_out) s_axi_arvalid_in <= 1'h0;
		end while (!s_axi_rvalid_out);
		v = s_axi_rdata_out;
		s_axi_rready_in <= 1'h0;
		`CHK("rresp", er, s_axi_rresp_out)
	endtask

	task automatic setpsw(input logic [15:0] v);
		axi_wr(`OFS_PSW, {16'h0, v}, 2'h0);
	endtask

	task automatic expect_ev(input logic [15:0] e, input logic [15:0] m = 16'hffff);
		logic [15:0] g;
		repeat (40) if (evq.size() == 0) @(posedge clk_in);
		g = (evq.size() != 0) ? evq.pop_front() : 16'hxxxx;
		`CHK("event", e & m, g & m)
	endtask

	task automatic expect_none(input int n);
		repeat (n) @(posedge clk_in);
		`CHK("idle", 0, evq.size())
	endtask

	task automatic drop();
		@(posedge clk_in);
		pl <= 3'h0;
		// let the released level clear the synchroniser before the mask moves again
		repeat (6) @(posedge clk_in);
	endtask

	task automatic irq(input logic [2:0] lv, input logic [1:0] md, input logic [7:0] v,
		input logic slow, input logic keep);
		@(posedge clk_in);
		pl <= lv;
		pm <= md;
		ps <= slow;
		expect_ev(tk(v, FR_FOUR));
		`CHK("ack", {4'hf, 1'h0, lv}, ack_info)
		`CHK("psw", {5'h04, lv, 8'h00}, processor_status_word_out)
		if (!keep) drop();
	endtask

	// q = {return, flow change, not executed, halt op, forced}
	task automatic instr(input logic [4:0] q);
		@(posedge clk_in);
		instr_start_in <= 1'h1;
		@(posedge clk_in);
		instr_start_in <= 1'h0;
		ret_req_in <= q[4];
		@(posedge clk_in);
		ret_req_in <= 1'h0;
		instr_done_in <= 1'h1;
		{flow_change_in, not_executed_in, halt_op_in, forced_exc_in} <= q[3:0];
		@(posedge clk_in);
		instr_done_in <= 1'h0;
		{flow_change_in, not_executed_in, halt_op_in, forced_exc_in} <= 4'h0;
	endtask

	// fl = {access error, fault during exception}
	task automatic return_from_exception_op(input logic [3:0] f, input logic [15:0] w, input logic [1:0] fl,
		input logic go);
		@(posedge clk_in);
		ret_format_in <= f;
		ret_word14_in <= w;
		{ret_access_err_in, ret_exc_fault_in} <= fl;
		ret_req_in <= go;
		@(posedge clk_in);
		ret_req_in <= 1'h0;
	endtask

	// ************************************************************
	// tests
	// ************************************************************
	initial begin
		// the whole run needs well under a thousand cycles
		repeat (30000) @(posedge clk_in);
		miscompares++;
		test_done();
	end

	initial begin
		rst_in <= 1'h1;
		repeat (10) @(posedge clk_in);
		rst_in <= 1'h0;
		repeat (2) @(posedge clk_in);
		axi_rd(`OFS_PSW, d, 2'h0);
		`CHK("psw reset", `PSW_RESET, d[15:0])
		axi_rd(8'h0c, d, 2'h3);
		`CHK("unmapped data", 32'h0, d)
		axi_wr(8'h0c, 32'h0, 2'h3);
		axi_rd(`OFS_VERSION, d, 2'h0);
		`CHK("version", `CPU_VERSION, d[7:0])
		for (int i = 1; i < 7; i++) begin
			setpsw(16'h0000);
			irq(3'(i), 2'h1, 8'(24 + i), 1'(i), 1'h0);
		end
		setpsw(16'h0000);
		irq(3'h6, 2'h2, `VEC_SPURIOUS, 1'h0, 1'h0);
		setpsw(16'h0000);
		irq(3'h2, 2'h3, 8'h0f, 1'h1, 1'h0);
		setpsw(16'h0300);
		@(posedge clk_in);
		pl <= 3'h5;
		pm <= 2'h0;
		@(posedge clk_in);
		pl <= 3'h0;
		expect_none(10);
		pl <= 3'h3;
		expect_none(10);
		setpsw(16'h0200);
		expect_ev(tk(8'h40, FR_FOUR));
		drop();
		setpsw(16'h0700);
		irq(3'h7, 2'h1, 8'h1f, 1'h0, 1'h1);
		expect_none(10);
		setpsw(16'h0500);
		expect_ev(tk(8'h1f, FR_FOUR));
		drop();
		setpsw(16'h8000);
		instr(5'h00);
		expect_ev(tk(`VEC_TRACE, FR_SIX));
		`CHK("trace bits", 2'h0, processor_status_word_out[15:14])
		`CHK("stacked psw", 1'h1, exc_psw_out[15])
		setpsw(16'h8000);
		instr(5'h04);
		expect_none(8);
		instr(5'h01);
		expect_ev(tk(8'h20, FR_FOUR), 16'hfcff);
		expect_ev(tk(`VEC_TRACE, FR_SIX));
		setpsw(16'h8000);
		instr(5'h02);
		expect_ev(tk(`VEC_TRACE, FR_SIX));
		`CHK("stop inhibit", 1, stop_cnt)
		setpsw(16'h4000);
		instr(5'h00);
		expect_none(8);
		instr(5'h08);
		expect_ev(tk(`VEC_TRACE, FR_SIX));
		setpsw(16'h0000);
		instr(5'h08);
		expect_none(8);
		@(posedge clk_in);
		boundary_in <= 1'h0;
		setpsw(16'h8000);
		pl <= 3'h4;
		pm <= 2'h1;
		breakpoint_in <= 1'h1;
		instr(5'h00);
		boundary_in <= 1'h1;
		expect_ev(tk(`VEC_TRACE, FR_SIX));
		expect_ev(16'h8000);
		expect_ev(tk(8'h1c, FR_FOUR));
		drop();
		return_from_exception_op(`FMT_FOUR, 16'h0, 2'h0, 1'h1);
		expect_ev(16'h2008);
		`CHK("psw", 16'h2500, processor_status_word_out)
		return_from_exception_op(`FMT_SIX, 16'h0, 2'h0, 1'h1);
		expect_ev(16'h200c);
		return_from_exception_op(`FMT_BUS, {`CPU_VERSION, 8'h00}, 2'h0, 1'h1);
		expect_ev(16'h2018);
		return_from_exception_op(`FMT_BUS, {(~`CPU_VERSION), 8'h00}, 2'h0, 1'h1);
		expect_ev(tk(`VEC_FMT_ERR, FR_FOUR));
		return_from_exception_op(4'h5, 16'h0, 2'h0, 1'h1);
		expect_ev(tk(`VEC_FMT_ERR, FR_FOUR));
		return_from_exception_op(`FMT_FOUR, 16'h0, 2'h2, 1'h1);
		expect_ev(tk(`VEC_BUS_ERR, FR_BERR));
		setpsw(16'h8000);
		return_from_exception_op(`FMT_BUS, {`CPU_VERSION, 8'h00}, 2'h0, 1'h0);
		instr(5'h10);
		expect_ev(16'h2018);
		expect_none(8);
		return_from_exception_op(`FMT_BUS, {`CPU_VERSION, 8'h00}, 2'h1, 1'h1);
		expect_ev(16'h2018);
		rw_fail <= 1'h1;
		return_from_exception_op(`FMT_BUS, {`CPU_VERSION, 8'h00}, 2'h1, 1'h1);
		repeat (20) if (!halted_out) @(posedge clk_in);
		`CHK("halted", 1'h1, halted_out)
		axi_rd(`OFS_STATUS, d, 2'h0);
		`CHK("status", {16'h0000, `VEC_BUS_ERR, 8'hc0}, d)
		test_done();
	end
endmodule // tb_cpu_exception_sequencer

// ---- hdl/cpu_exception_sequencer.sv ----
`include "exc_seq_params.svh"

module cpu_exception_sequencer #(
	parameter logic [7:0] VERSION = `CPU_VERSION  // arbitrary value
) (
	// clock and reset
	input  wire logic                      clk_in,
	input  wire logic                      rst_in,
	// axi4-lite slave
	input  wire logic [7:0]                s_axi_awaddr_in,
	input  wire logic                      s_axi_awvalid_in,
	output      logic                      s_axi_awready_out,
	input  wire logic [31:0]               s_axi_wdata_in,
	input  wire logic [3:0]                s_axi_wstrb_in,
	input  wire logic                      s_axi_wvalid_in,
	output      logic                      s_axi_wready_out,
	output      logic [1:0]                s_axi_bresp_out,
	output      logic                      s_axi_bvalid_out,
	input  wire logic                      s_axi_bready_in,
	input  wire logic [7:0]                s_axi_araddr_in,
	input  wire logic                      s_axi_arvalid_in,
	output      logic                      s_axi_arready_out,
	output      logic [31:0]               s_axi_rdata_out,
	output      logic [1:0]                s_axi_rresp_out,
	output      logic                      s_axi_rvalid_out,
	input  wire logic                      s_axi_rready_in,
	// instruction events from the core
	input  wire logic                      instr_start_in,
	input  wire logic                      instr_done_in,
	input  wire logic                      flow_change_in,
	input  wire logic                      not_executed_in,
	input  wire logic                      halt_op_in,
	input  wire logic                      forced_exc_in,
	input  wire logic [7:0]                forced_vec_in,
	input  wire logic                      boundary_in,
	input  wire logic                      breakpoint_in,
	// interrupt request pins and acknowledge cycle
	input  wire logic [2:0]                interrupt_request_lines_in,
	input  wire logic                      iack_done_in,
	input  wire logic                      iack_berr_in,
	input  wire logic                      iack_autovec_in,
	input  wire logic [7:0]                iack_vector_in,
	output      logic                      iack_req_out,
	output      logic [2:0]                iack_level_out,
	output      logic [3:0]                iack_space_out,
	// return from exception frame
	input  wire logic                      ret_req_in,
	input  wire logic [3:0]                ret_format_in,
	input  wire logic [15:0]               ret_psw_in,
	input  wire logic [15:0]               ret_word14_in,
	input  wire logic                      ret_access_err_in,
	input  wire logic                      ret_exc_fault_in,
	input  wire logic                      rewrite_ok_in,
	input  wire logic                      rewrite_err_in,
	output      logic                      rewrite_req_out,
	output      logic                      ret_done_out,
	output      logic [4:0]                sp_increment_out,
	// exception start towards the core
	output      logic                      exc_take_out,
	output      logic [7:0]                exc_vector_out,
	output      exc_seq_pkg::frame_t       exc_frame_out,
	output      logic [15:0]               exc_psw_out,
	output      logic                      bkpt_ack_out,
	output      logic                      stop_inhibit_out,
	output      logic                      halted_out,
	output      logic [15:0]               processor_status_word_out
);
	import exc_seq_pkg::*;

	typedef struct packed {
		seq_state_t  st;
		logic [15:0] psw;
		trace_mode_t tr_start;
		logic        trace_pend;
		logic        forced_pend;
		logic [7:0]  forced_vec;
		logic        no_trace;
		logic [2:0]  s1, s2, s3;
		logic [2:0]  lvl, lvl_prev, mask_prev;
		logic        nmi_pend;
		logic        iack_req;
		logic [2:0]  iack_lvl;
		logic [3:0]  iack_space;
		logic        take;
		logic [7:0]  vec;
		frame_t      frame;
		logic [15:0] exc_psw;
		logic        bkpt_ack, stop_inh, ret_done, rewr_req, halted;
		logic [4:0]  sp_inc;
		logic        awready, wready, aw_got, w_got, bvalid;
		logic [1:0]  bresp;
		logic [7:0]  awaddr;
		logic [31:0] wdata;
		logic [3:0]  wstrb;
		logic        arready, rvalid;
		logic [1:0]  rresp;
		logic [31:0] rdata;
	} state_t;

	state_t r, next_r;

	logic [2:0] mask;
	logic       irq_ok;
	logic       trace_hit;
	logic       nmi_edge;
	assign mask = r.psw[`PSW_MASK_HI:`PSW_MASK_LO];
	// level seven only by edge, others strictly above the mask
	assign irq_ok = (r.lvl == `LEVEL_NMI) ? r.nmi_pend : (r.lvl > mask);
	// aborted or unexecuted instructions report done but never raise a trace
	assign trace_hit = instr_done_in && !r.no_trace && !not_executed_in
		&& (r.tr_start == TR_EVERY || (r.tr_start == TR_FLOW && flow_change_in));
	assign nmi_edge = r.lvl == `LEVEL_NMI && (r.lvl_prev != `LEVEL_NMI
		|| (r.mask_prev == `LEVEL_NMI && mask != `LEVEL_NMI));

	// ************************************************************
	// next state
	// ************************************************************
	always_comb begin
		next_r = r;
		next_r.take = 1'b0;
		next_r.bkpt_ack = 1'b0;
		next_r.stop_inh = 1'b0;
		next_r.ret_done = 1'b0;

		// first stage feeds only the second
		next_r.s1 = interrupt_request_lines_in;
		next_r.s2 = r.s1;
		next_r.s3 = r.s2;
		if (r.s2 == r.s3) begin
			next_r.lvl = r.s2;
		end
		next_r.lvl_prev = r.lvl;
		next_r.mask_prev = mask;
		if (nmi_edge) begin
			next_r.nmi_pend = 1'b1;
		end

		// trace mode is sampled as the instruction begins
		if (instr_start_in) begin
			next_r.tr_start = trace_mode_t'(r.psw[`PSW_TRACE_EVERY:`PSW_TRACE_FLOW]);
		end
		if (forced_exc_in) begin
			next_r.forced_pend = 1'b1;
			next_r.forced_vec = forced_vec_in;
		end
		if (instr_done_in) begin
			next_r.no_trace = 1'b0;
			if (trace_hit) begin
				next_r.trace_pend = 1'b1;
			end
			if (halt_op_in && r.tr_start == TR_EVERY) begin
				next_r.stop_inh = 1'b1;
			end
		end

		case (r.st)
			ST_RUN: begin
				// one start or acknowledge per boundary; a source sees the ack a cycle late
				if (boundary_in && !r.take && !r.bkpt_ack) begin
					// a new event in the same cycle outlives the clear
					if (r.forced_pend) begin
						next_r.forced_pend = forced_exc_in;
						next_r.take = 1'b1;
						next_r.vec = r.forced_vec;
						next_r.frame = FR_FOUR;
					end else if (r.trace_pend) begin
						next_r.trace_pend = trace_hit;
						next_r.take = 1'b1;
						next_r.vec = `VEC_TRACE;
						next_r.frame = FR_SIX;
					end else if (breakpoint_in) begin
						next_r.bkpt_ack = 1'b1;
					end else if (r.lvl != 3'h0 && irq_ok) begin
						if (r.lvl == `LEVEL_NMI) begin
							next_r.nmi_pend = nmi_edge;
						end
						next_r.exc_psw = r.psw;
						next_r.iack_req = 1'b1;
						next_r.iack_lvl = r.lvl;
						next_r.iack_space = `IACK_SPACE;
						next_r.st = ST_IACK;
					end
					if (next_r.take) begin
						next_r.exc_psw = r.psw;
					end
				end
				if (ret_req_in) begin
					next_r.sp_inc = 5'h00;
					if (ret_access_err_in) begin
						next_r.take = 1'b1;
						next_r.vec = `VEC_BUS_ERR;
						next_r.frame = FR_BERR;
						next_r.exc_psw = r.psw;
					end else if (ret_format_in == `FMT_FOUR) begin
						next_r.psw = ret_psw_in;
						next_r.sp_inc = `SP_INC_FOUR;
						next_r.ret_done = 1'b1;
					end else if (ret_format_in == `FMT_SIX) begin
						next_r.psw = ret_psw_in;
						next_r.sp_inc = `SP_INC_SIX;
						next_r.ret_done = 1'b1;
					end else if (ret_format_in == `FMT_BUS
						&& ret_word14_in[15:8] == VERSION) begin
						next_r.psw = ret_psw_in;
						next_r.sp_inc = `SP_INC_BUS;
						next_r.no_trace = 1'b1;
						if (ret_exc_fault_in) begin
							next_r.rewr_req = 1'b1;
							next_r.st = ST_REWR;
						end else begin
							next_r.ret_done = 1'b1;
						end
					end else begin
						next_r.take = 1'b1;
						next_r.vec = `VEC_FMT_ERR;
						next_r.frame = FR_FOUR;
						next_r.exc_psw = r.psw;
					end
				end
			end
			ST_IACK: begin
				// status word switches here while the acknowledge runs, not in the block below
				next_r.psw[`PSW_SUPER] = 1'b1;
				next_r.psw[`PSW_TRACE_EVERY] = 1'b0;
				next_r.psw[`PSW_TRACE_FLOW] = 1'b0;
				next_r.psw[`PSW_MASK_HI:`PSW_MASK_LO] = r.iack_lvl;
				if (iack_done_in) begin
					next_r.iack_req = 1'b0;
					next_r.take = 1'b1;
					next_r.frame = FR_FOUR;
					if (iack_berr_in) begin
						next_r.vec = `VEC_SPURIOUS;
					end else if (iack_autovec_in) begin
						next_r.vec = `VEC_SPURIOUS + {5'h00, r.iack_lvl};
					end else begin
						next_r.vec = iack_vector_in;
					end
					next_r.st = ST_RUN;
				end
			end
			ST_REWR: begin
				if (rewrite_err_in) begin
					next_r.rewr_req = 1'b0;
					next_r.st = ST_HALT;
				end else if (rewrite_ok_in) begin
					next_r.rewr_req = 1'b0;
					next_r.ret_done = 1'b1;
					next_r.st = ST_RUN;
				end
			end
			ST_HALT: begin
				next_r.st = ST_HALT;
			end
			default: begin
				next_r.st = ST_RUN;
			end
		endcase
		next_r.halted = (next_r.st == ST_HALT);

		// every exception start enters supervisor with tracing off
		if (next_r.take && r.st != ST_IACK) begin
			next_r.psw[`PSW_SUPER] = 1'b1;
			next_r.psw[`PSW_TRACE_EVERY] = 1'b0;
			next_r.psw[`PSW_TRACE_FLOW] = 1'b0;
		end

		// ************************************************************
		// axi4-lite write
		// ************************************************************
		if (s_axi_awvalid_in && r.awready) begin
			next_r.aw_got = 1'b1;
			next_r.awaddr = s_axi_awaddr_in;
		end
		if (s_axi_wvalid_in && r.wready) begin
			next_r.w_got = 1'b1;
			next_r.wdata = s_axi_wdata_in;
			next_r.wstrb = s_axi_wstrb_in;
		end
		if (r.aw_got && r.w_got && !r.bvalid) begin
			next_r.aw_got = 1'b0;
			next_r.w_got = 1'b0;
			next_r.bvalid = 1'b1;
			next_r.bresp = 2'h0;
			if (r.awaddr == `OFS_PSW) begin
				// a hardware update of the status word in this cycle wins over the write
				if (next_r.psw == r.psw) begin
					if (r.wstrb[0]) begin
						next_r.psw[7:0] = r.wdata[7:0];
					end
					if (r.wstrb[1]) begin
						next_r.psw[15:8] = r.wdata[15:8];
					end
				end
			end else if (r.awaddr != `OFS_STATUS && r.awaddr != `OFS_VERSION) begin
				next_r.bresp = 2'h3;
			end
		end else if (r.bvalid && s_axi_bready_in) begin
			next_r.bvalid = 1'b0;
		end
		next_r.awready = !next_r.aw_got && !next_r.bvalid;
		next_r.wready = !next_r.w_got && !next_r.bvalid;

		// ************************************************************
		// axi4-lite read
		// ************************************************************
		if (s_axi_arvalid_in && r.arready) begin
			next_r.rvalid = 1'b1;
			next_r.rresp = 2'h0;
			case (s_axi_araddr_in)
				`OFS_PSW: next_r.rdata = {16'h0000, r.psw};
				`OFS_STATUS: next_r.rdata = {16'h0000, r.vec, r.st, r.nmi_pend,
					r.trace_pend, r.forced_pend, r.lvl};
				`OFS_VERSION: next_r.rdata = {24'h000000, VERSION};
				default: begin
					next_r.rdata = 32'h00000000;
					next_r.rresp = 2'h3;
				end
			endcase
		end else if (r.rvalid && s_axi_rready_in) begin
			next_r.rvalid = 1'b0;
		end
		next_r.arready = !next_r.rvalid;
	end

	// ************************************************************
	// state register
	// ************************************************************
	always_ff @(posedge clk_in or posedge rst_in) begin
		if (rst_in) begin
			r <= '0;
			r.psw <= `PSW_RESET;
			r.frame <= FR_NONE;
		end else begin
			r <= next_r;
		end
	end

	assign s_axi_awready_out = r.awready;
	assign s_axi_wready_out = r.wready;
	assign s_axi_bvalid_out = r.bvalid;
	assign s_axi_bresp_out = r.bresp;
	assign s_axi_arready_out = r.arready;
	assign s_axi_rvalid_out = r.rvalid;
	assign s_axi_rdata_out = r.rdata;
	assign s_axi_rresp_out = r.rresp;
	assign iack_req_out = r.iack_req;
	assign iack_level_out = r.iack_lvl;
	assign iack_space_out = r.iack_space;
	assign rewrite_req_out = r.rewr_req;
	assign ret_done_out = r.ret_done;
	assign sp_increment_out = r.sp_inc;
	assign exc_take_out = r.take;
	assign exc_vector_out = r.vec;
	assign exc_frame_out = r.frame;
	assign exc_psw_out = r.exc_psw;
	assign bkpt_ack_out = r.bkpt_ack;
	assign stop_inhibit_out = r.stop_inh;
	assign halted_out = r.halted;
	assign processor_status_word_out = r.psw;

	// ************************************************************
	// assertions
	// ************************************************************
	default clocking cb @(posedge clk_in); endclocking
	default disable iff (rst_in);

	property p_spurious;
		r.st == ST_IACK && iack_done_in && iack_berr_in |=> r.take && r.vec == 8'h18;
	endproperty
	a_spurious: assert property (p_spurious) else $error("spurious vector wrong");

	property p_autovec;
		r.st == ST_IACK && iack_done_in && !iack_berr_in && iack_autovec_in
			|=> r.vec == 8'h18 + {5'h00, $past(r.iack_lvl)};
	endproperty
	a_autovec: assert property (p_autovec) else $error("autovector wrong");

	property p_accept_psw;
		$rose(r.iack_req) |=> r.psw[13] && r.psw[15:14] == 2'h0
			&& r.psw[10:8] == r.iack_lvl;
	endproperty
	a_accept_psw: assert property (p_accept_psw) else $error("accept psw wrong");

	property p_masked;
		$rose(r.iack_req) |-> $past(r.lvl) > $past(mask) || $past(r.lvl) == 3'h7;
	endproperty
	a_masked: assert property (p_masked) else $error("masked level taken");

	property p_nmi_edge;
		r.lvl == 3'h7 && r.lvl_prev != 3'h7 |=> r.nmi_pend || r.iack_req;
	endproperty
	a_nmi_edge: assert property (p_nmi_edge) else $error("level seven edge lost");

	property p_stable;
		r.lvl != $past(r.lvl) |-> $past(r.s2) == $past(r.s3);
	endproperty
	a_stable: assert property (p_stable) else $error("unstable level taken");

	property p_forced_first;
		r.st == ST_RUN && boundary_in && !r.take && r.forced_pend && r.trace_pend
			&& !ret_req_in |=> r.take && r.vec == $past(r.forced_vec) ##1 boundary_in
			|-> ##1 r.vec == 8'h09;
	endproperty
	a_forced_first: assert property (p_forced_first) else $error("trace before forced");

	property p_four_frame;
		r.st == ST_RUN && ret_req_in && !ret_access_err_in && ret_format_in == 4'h0
			|=> r.sp_inc == 5'h08 && r.ret_done;
	endproperty
	a_four_frame: assert property (p_four_frame) else $error("four-word release wrong");

	property p_rewrite_halt;
		r.st == ST_REWR && rewrite_err_in |=> halted_out [*2];
	endproperty
	a_rewrite_halt: assert property (p_rewrite_halt) else $error("no halt on rewrite fail");

	property p_fmt_err;
		r.st == ST_RUN && ret_req_in && !ret_access_err_in && ret_format_in != 4'h0
			&& ret_format_in != 4'h2 && ret_format_in != 4'hc
			|=> r.take && r.vec == 8'h0e && r.sp_inc == 5'h00 && !r.ret_done;
	endproperty
	a_fmt_err: assert property (p_fmt_err) else $error("format error wrong");

endmodule // cpu_exception_sequencer

// ---- pkg/exc_seq_params.svh ----
`ifndef EXC_SEQ_PARAMS_SVH
`define EXC_SEQ_PARAMS_SVH

// ************************************************************
// register offsets (byte addresses)
// ************************************************************
`define OFS_PSW         8'h00
`define OFS_STATUS      8'h04
`define OFS_VERSION     8'h08

// ************************************************************
// status word fields and reset value
// ************************************************************
`define PSW_TRACE_EVERY 15
`define PSW_TRACE_FLOW  14
`define PSW_SUPER       13
`define PSW_MASK_HI     10
`define PSW_MASK_LO     8
`define PSW_RESET       16'h2700

// ************************************************************
// vector numbers
// ************************************************************
`define VEC_SPURIOUS    8'h18
`define VEC_TRACE       8'h09
`define VEC_BKPT        8'h0c
`define VEC_FMT_ERR     8'h0e
`define VEC_BUS_ERR     8'h02

// ************************************************************
// frame formats, stack release and acknowledge space
// ************************************************************
`define FMT_FOUR        4'h0
`define FMT_SIX         4'h2
`define FMT_BUS         4'hc
`define SP_INC_FOUR     5'h08
`define SP_INC_SIX      5'h0c
`define SP_INC_BUS      5'h18
`define IACK_SPACE      4'hf
`define LEVEL_NMI       3'h7
`define CPU_VERSION     8'h01

`endif

// ---- pkg/exc_seq_pkg.sv ----
package exc_seq_pkg;
	typedef enum logic [1:0] {
		ST_RUN    = 2'b00,
		ST_IACK   = 2'b01,
		ST_REWR   = 2'b10,
		ST_HALT   = 2'b11
	} seq_state_t;

	typedef enum logic [1:0] {
		FR_FOUR   = 2'b00,
		FR_SIX    = 2'b01,
		FR_BERR   = 2'b10,
		FR_NONE   = 2'b11
	} frame_t;

	typedef enum logic [1:0] {
		TR_OFF    = 2'b00,
		TR_FLOW   = 2'b01,
		TR_EVERY  = 2'b10,
		TR_RSVD   = 2'b11
	} trace_mode_t;
endpackage
